/* rtl/fsto_regs.sv */
// register bank: fifo status, pressure limit and pressure trim
`timescale 1ns/1ps
module fsto_regs (
  input  wire logic        sys_clk,                // system clock 40 mhz
  input  wire logic        reset,                  // async reset, high
  input  wire logic [7:0]  reg_addr,               // register offset
  input  wire logic        reg_wr,                 // write strobe pulse
  input  wire logic [7:0]  reg_wdata,              // write data
  input  wire logic        reg_rd,                 // read strobe pulse
  output logic [7:0]       reg_rdata,              // read data, next cycle
  input  wire logic        sample_push,            // new sample stored
  input  wire logic        sample_pop,             // sample read out
  input  wire logic        press_valid,            // new pressure pulse
  input  wire logic [15:0] press_diff,             // signed differential
  input  wire logic        high_event_enable,      // high event enable
  input  wire logic        low_event_enable,       // low event enable
  output logic             high_event,             // above limit, held
  output logic             low_event,              // below limit, held
  output logic             press_event_req,        // either event
  output logic [15:0]      pressure_limit,         // limit register
  output logic [15:0]      pressure_trim,          // trim register
  output logic [2:0]       fifo_mode,              // control mode field
  output logic [4:0]       watermark_level,        // control level field
  output logic             watermark_reached_flag, // count >= level
  output logic             overwrite_flag,         // overwrite status
  output logic             fifo_empty,             // no samples
  output logic [4:0]       fill_level              // stored data level
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl_q;  // fifo control byte
    logic [15:0] limit_q; // pressure limit
    logic [15:0] trim_q;  // pressure trim, two's complement
    logic [7:0]  rdata_q; // read data
    logic        high_q;  // high event request
    logic        low_q;   // low event request
  } fsto_regs_t;

  fsto_regs_t s_q; // registered state
  fsto_regs_t s_d; // next state

  logic [5:0] stored_count; // samples held
  logic [7:0] status_byte;  // assembled status

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pick one byte of a 16 bit register
  function automatic logic [7:0] byte_of(input logic [15:0] v,
                                         input logic        hi);
    byte_of = hi ? v[15:8] : v[7:0];
  endfunction

  // replace one byte of a 16 bit register
  function automatic logic [15:0] put_byte(input logic [15:0] v,
                                           input logic        hi,
                                           input logic [7:0]  b);
    put_byte = hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction

  // ----------------------------------------------------------------
  // fill tracking
  // ----------------------------------------------------------------
  fsto_fill_track u_track (
    .sys_clk        (sys_clk),
    .reset          (reset),
    .sample_push    (sample_push),
    .sample_pop     (sample_pop),
    .stored_count   (stored_count),
    .overwrite_flag (overwrite_flag)
  );

  // status fields from the live count
  always_comb begin
    fifo_empty             = (stored_count == 6'h00);
    // level is count minus one; empty also shows zero
    fill_level             = fifo_empty ? 5'h00
                             : 5'(stored_count - 6'h01);
    watermark_reached_flag = (stored_count >=
                              {1'b0, watermark_level});
    status_byte = {watermark_reached_flag, overwrite_flag,
                   fifo_empty, fill_level};
  end

  // ----------------------------------------------------------------
  // register access and event compare
  // ----------------------------------------------------------------
  logic signed [16:0] diff_ext;  // differential, sign extended
  logic signed [16:0] limit_pos; // +limit
  logic signed [16:0] limit_neg; // -limit
  assign diff_ext  = {press_diff[15], press_diff};
  assign limit_pos = {1'b0, s_q.limit_q};
  assign limit_neg = 17'(-limit_pos);

  always_comb begin
    s_d = s_q;
    // writes; status byte has no write path
    if (reg_wr) begin
      if (reg_addr == fsto_pkg::ADDR_FIFO_CTRL) begin
        s_d.ctrl_q = reg_wdata;
      end else if (reg_addr == fsto_pkg::ADDR_LIMIT_LOW) begin
        s_d.limit_q = put_byte(s_q.limit_q, 1'b0, reg_wdata);
      end else if (reg_addr == fsto_pkg::ADDR_LIMIT_HIGH) begin
        s_d.limit_q = put_byte(s_q.limit_q, 1'b1, reg_wdata);
      end else if (reg_addr == fsto_pkg::ADDR_TRIM_LOW) begin
        s_d.trim_q = put_byte(s_q.trim_q, 1'b0, reg_wdata);
      end else if (reg_addr == fsto_pkg::ADDR_TRIM_HIGH) begin
        s_d.trim_q = put_byte(s_q.trim_q, 1'b1, reg_wdata);
      end
    end
    // reads, data registered for the next cycle
    if (reg_rd) begin
      if (reg_addr == fsto_pkg::ADDR_FIFO_CTRL) begin
        s_d.rdata_q = s_q.ctrl_q;
      end else if (reg_addr == fsto_pkg::ADDR_FIFO_STATUS) begin
        s_d.rdata_q = status_byte;
      end else if (reg_addr == fsto_pkg::ADDR_LIMIT_LOW) begin
        s_d.rdata_q = byte_of(s_q.limit_q, 1'b0);
      end else if (reg_addr == fsto_pkg::ADDR_LIMIT_HIGH) begin
        s_d.rdata_q = byte_of(s_q.limit_q, 1'b1);
      end else if (reg_addr == fsto_pkg::ADDR_TRIM_LOW) begin
        s_d.rdata_q = byte_of(s_q.trim_q, 1'b0);
      end else if (reg_addr == fsto_pkg::ADDR_TRIM_HIGH) begin
        s_d.rdata_q = byte_of(s_q.trim_q, 1'b1);
      end else begin
        s_d.rdata_q = fsto_pkg::READ_ZERO; // unmapped offset
      end
    end
    // limit compared in raw units, value/16 hpa on both sides
    if (press_valid) begin
      s_d.high_q = high_event_enable && (diff_ext > limit_pos);
      s_d.low_q  = low_event_enable && (diff_ext < limit_neg);
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q.ctrl_q  <= fsto_pkg::CTRL_RST;
      s_q.limit_q <= fsto_pkg::LIMIT_RST;
      s_q.trim_q  <= fsto_pkg::TRIM_RST;
      s_q.rdata_q <= fsto_pkg::READ_ZERO;
      s_q.high_q  <= 1'b0;
      s_q.low_q   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from registers, except press_event_req, the or of high_q and low_q
  assign reg_rdata       = s_q.rdata_q;
  assign pressure_limit  = s_q.limit_q;
  assign pressure_trim   = s_q.trim_q;
  assign fifo_mode       = s_q.ctrl_q[7:fsto_pkg::MODE_LSB];
  assign watermark_level = s_q.ctrl_q[fsto_pkg::LEVEL_MSB:0];
  assign high_event      = s_q.high_q;
  assign low_event       = s_q.low_q;
  assign press_event_req = s_q.high_q || s_q.low_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  watermark_flag_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    watermark_reached_flag == (watermark_level == 5'd0
      || (!fifo_empty && fill_level >= 5'(watermark_level - 5'd1))))
    else $error("watermark flag disagrees with count");

  empty_flag_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    fifo_empty |-> fill_level == 5'd0 && !watermark_reached_flag
                   || watermark_level == 5'd0)
    else $error("empty fifo shows stored data");

  full_level_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (stored_count == 6'd32) |-> fill_level == 5'h1F && !fifo_empty)
    else $error("full fifo does not show level 11111");

  status_read_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (reg_rd && reg_addr == fsto_pkg::ADDR_FIFO_STATUS
     && !sample_push && !sample_pop)
      |=> reg_rdata[4:0] == fill_level && reg_rdata[5] == fifo_empty)
    else $error("status read returned wrong level");

  limit_high_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == fsto_pkg::ADDR_LIMIT_HIGH)
      |=> pressure_limit[15:8] == $past(reg_wdata)
          && pressure_limit[7:0] == $past(pressure_limit[7:0]))
    else $error("limit high byte write misplaced");

  trim_write_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == fsto_pkg::ADDR_TRIM_LOW)
      |=> pressure_trim[7:0] == $past(reg_wdata)
          && pressure_trim[15:8] == $past(pressure_trim[15:8]))
    else $error("trim low byte write misplaced");

  status_write_ignored_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == fsto_pkg::ADDR_FIFO_STATUS)
      |=> $stable(pressure_limit) && $stable(pressure_trim)
          && $stable(watermark_level))
    else $error("status write changed a register");

  high_event_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (press_valid && high_event_enable
     && $signed({press_diff[15], press_diff})
        > $signed({1'b0, pressure_limit}))
      |=> high_event && press_event_req)
    else $error("high event not raised above limit");

  event_disabled_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (press_valid && !low_event_enable) |=> !low_event)
    else $error("low event raised while disabled");
endmodule

/* rtl/fsto_pkg.sv */
// package: register map, field positions, reset values for the fifo status bank
package fsto_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FIFO_CTRL   = 8'h2E; // watermark level + mode
  localparam logic [7:0] ADDR_FIFO_STATUS = 8'h2F; // read only status
  localparam logic [7:0] ADDR_LIMIT_LOW   = 8'h30; // pressure limit [7:0]
  localparam logic [7:0] ADDR_LIMIT_HIGH  = 8'h31; // pressure limit [15:8]
  localparam logic [7:0] ADDR_TRIM_LOW    = 8'h39; // pressure trim [7:0]
  localparam logic [7:0] ADDR_TRIM_HIGH   = 8'h3A; // pressure trim [15:8]

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WMARK_BIT   = 7; // watermark reached flag
  localparam int OVWR_BIT    = 6; // overwrite flag
  localparam int EMPTY_BIT   = 5; // fifo empty flag
  localparam int LEVEL_MSB   = 4; // fill level top bit
  localparam int MODE_LSB    = 5; // fifo mode field low bit in control
  localparam int LIMIT_FRAC  = 4; // limit in hpa is value / 16 (shift)

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int          FIFO_DEPTH  = 32;       // maximum stored samples
  localparam logic [5:0]  DEPTH_COUNT = 6'h20;    // depth at count width
  localparam logic [7:0]  CTRL_RST    = 8'h00;    // control reset value
  localparam logic [15:0] LIMIT_RST   = 16'h0000; // limit reset value
  localparam logic [15:0] TRIM_RST    = 16'h0000; // trim reset value
  localparam logic [7:0]  READ_ZERO   = 8'h00;    // unmapped read value
endpackage

/* rtl/fsto_fill_track.sv */
// fill tracker: stored sample count and overwrite flag
`timescale 1ns/1ps
module fsto_fill_track (
  input  wire logic       sys_clk,       // system clock
  input  wire logic       reset,         // async reset, active high
  input  wire logic       sample_push,   // one new sample stored
  input  wire logic       sample_pop,    // one sample read out
  output logic [5:0]      stored_count,  // samples held, 0..32
  output logic            overwrite_flag // full and a sample was lost
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] count_q; // samples currently held
    logic       ovwr_q;  // overwrite seen since last read out
  } fsto_track_t;

  fsto_track_t s_q; // registered state
  fsto_track_t s_d; // next state

  logic full; // fifo holds maximum depth
  logic pop;  // read out with something to give
  assign full = (s_q.count_q == fsto_pkg::DEPTH_COUNT);
  assign pop  = sample_pop && (s_q.count_q != 6'h00);

  // next state: push, pop, overwrite when full
  always_comb begin
    s_d = s_q;
    if (sample_push && !pop && full) begin
      // newest sample replaces oldest, count stays at depth
      s_d.ovwr_q = 1'b1;
    end else if (sample_push && !pop) begin
      s_d.count_q = s_q.count_q + 6'h01;
    end else if (pop && !sample_push) begin
      s_d.count_q = s_q.count_q - 6'h01;
      s_d.ovwr_q  = 1'b0;
    end else if (pop) begin
      // push and pop together: count kept, space existed
      s_d.ovwr_q = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stored_count   = s_q.count_q;
  assign overwrite_flag = s_q.ovwr_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  overwrite_when_full_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    overwrite_flag |-> stored_count == 6'd32)
    else $error("overwrite flag set while fifo not full");

  pop_decrements_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (sample_pop && !sample_push && stored_count != 6'd0)
      |=> stored_count == $past(stored_count) - 6'd1)
    else $error("fill level did not drop after a read out");

  push_full_sets_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (sample_push && !sample_pop && stored_count == 6'd32)
      |=> overwrite_flag && stored_count == 6'd32)
    else $error("overwrite on full fifo not flagged");
endmodule

/* test/fsto_host_model.sv */
// host model: drives the byte wide register strobes of the bank
`timescale 1ns/1ps
module fsto_host_model (
  input  wire logic       sys_clk,   // system clock
  output logic [7:0]      reg_addr,  // register offset
  output logic            reg_wr,    // write strobe
  output logic [7:0]      reg_wdata, // write data
  output logic            reg_rd     // read strobe
);
  // ----------------------------------------------------------
  // bus cycles, launched off the falling edge
  // ----------------------------------------------------------
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // one byte write; also how the trim is loaded for calibration
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a; // released lines never keep the last value
    reg_wdata = ~d;
  endtask
  // one byte read; data is taken by the bench one edge later
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

/* test/testbench.sv */
// testbench: self checking run of the fifo status and limit bank
`timescale 1ns/1ps
module testbench;
  logic        sys_clk, reset, reg_wr, reg_rd;   // clock, reset, strobes
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;   // register port
  logic        sample_push, sample_pop;          // fifo pulses
  logic        press_valid, high_event_enable, low_event_enable;
  logic [15:0] press_diff, pressure_limit, pressure_trim;
  logic        high_event, low_event, press_event_req;
  logic [2:0]  fifo_mode;                        // mode field
  logic [4:0]  watermark_level, fill_level;      // level fields
  logic        watermark_reached_flag, overwrite_flag, fifo_empty;
  logic [7:0]  rd_q[$];                          // expected read data
  logic [2:0]  ev_q[$];                          // expected events
  logic        rd_pend, ev_pend;                 // result due now
  logic [31:0] seed;                             // xorshift state
  int          failures, tests_run, cycles;      // counters
  fsto_regs fsto_regs_inst (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_push(sample_push),
    .sample_pop(sample_pop), .press_valid(press_valid),
    .press_diff(press_diff), .high_event_enable(high_event_enable),
    .low_event_enable(low_event_enable), .high_event(high_event),
    .low_event(low_event), .press_event_req(press_event_req),
    .pressure_limit(pressure_limit), .pressure_trim(pressure_trim),
    .fifo_mode(fifo_mode), .watermark_level(watermark_level),
    .watermark_reached_flag(watermark_reached_flag),
    .overwrite_flag(overwrite_flag), .fifo_empty(fifo_empty),
    .fill_level(fill_level));
  fsto_host_model fsto_host_model_inst (.sys_clk(sys_clk),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd));
  // ----------------------------------------------------------
  // clock, helpers and compare tasks
  // ----------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // xorshift step on the shared seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected status byte for a count, level and overwrite state
  function automatic logic [7:0] st(input int c, input logic [4:0] w,
                                    input logic ov);
    return {c >= w, ov, c == 0, (c == 0) ? 5'h00 : 5'(c - 1)};
  endfunction
  task automatic cmp_val(input string n, input logic [15:0] e,
                         input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp_ev(input logic [2:0] e, input logic [2:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[ERR] events expected %b seen %b", e, s);
    end
  endtask
  // note the expected byte, then read it
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    fsto_host_model_inst.rd(a);
  endtask
  task automatic pulse(input logic p, input logic q);
    @(negedge sys_clk);
    sample_push = p;
    sample_pop  = q;
    @(negedge sys_clk);
    sample_push = 1'b0;
    sample_pop  = 1'b0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------
  // watcher: a result appears one edge after its strobe
  // ----------------------------------------------------------
  always @(posedge sys_clk) begin
    rd_pend <= reg_rd && !reset;
    ev_pend <= press_valid && !reset;
    cycles  <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      end_sim();
    end
  end
  always @(negedge sys_clk) begin
    if (rd_pend && rd_q.size() > 0) cmp_val("reg_rdata", rd_q.pop_front(),
                                            {8'h00, reg_rdata});
    if (ev_pend && ev_q.size() > 0) cmp_ev(ev_q.pop_front(),
                              {high_event, low_event, press_event_req});
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [7:0]  adr [4];
    logic [7:0]  d [4];
    logic [4:0]  w;
    logic [1:0]  en;
    int          lim, dv;
    reset = 1'b1; sample_push = 1'b0; sample_pop = 1'b0;
    press_valid = 1'b0; press_diff = 16'h0000;
    high_event_enable = 1'b0; low_event_enable = 1'b0;
    seed = 32'hbd74_dfb7; failures = 0; tests_run = 0; cycles = 0;
    rd_pend = 1'b0; ev_pend = 1'b0;
    adr = '{fsto_pkg::ADDR_LIMIT_LOW, fsto_pkg::ADDR_LIMIT_HIGH,
            fsto_pkg::ADDR_TRIM_LOW, fsto_pkg::ADDR_TRIM_HIGH};
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    chk(fsto_pkg::ADDR_FIFO_STATUS, st(0, 5'h00, 1'b0));
    foreach (adr[i]) chk(adr[i], 8'h00);
    $display("test reset done");
    // byte registers, then a write and a read at an unmapped place
    foreach (adr[i]) begin
      d[i] = 8'(rnd());
      if (i == 1) d[i] = d[i] & 8'h7f;
      fsto_host_model_inst.wr(adr[i], d[i]);
    end
    fsto_host_model_inst.wr(8'h3b, 8'h55);
    foreach (adr[i]) chk(adr[i], d[i]);
    chk(8'h3b, fsto_pkg::READ_ZERO);
    cmp_val("pressure_limit", {d[1], d[0]}, pressure_limit);
    cmp_val("pressure_trim", {d[3], d[2]}, pressure_trim);
    $display("test registers done");
    // pressure events against the limit
    lim = int'({d[1], d[0]});
    for (int i = 0; i < 24; i++) begin
      en = 2'(rnd());
      case (i % 5)
        0: dv = lim + 1;
        1: dv = lim;
        2: dv = -lim - 1;
        3: dv = -lim;
        default: dv = int'($signed(rnd() & 32'h0000_ffff));
      endcase
      @(negedge sys_clk);
      press_diff = 16'(dv);
      high_event_enable = en[1];
      low_event_enable = en[0];
      press_valid = 1'b1;
      dv = int'($signed(16'(dv)));
      ev_q.push_back({en[1] && dv > lim, en[0] && dv < -lim,
                      (en[1] && dv > lim) || (en[0] && dv < -lim)});
      @(negedge sys_clk);
      press_valid = 1'b0;
    end
    $display("test events done");
    // fill past full, then drain past empty
    w = 5'(rnd());
    fsto_host_model_inst.wr(fsto_pkg::ADDR_FIFO_CTRL, {3'b010, w});
    chk(fsto_pkg::ADDR_FIFO_CTRL, {3'b010, w});
    cmp_val("ctrl_ports", {8'h00, 3'b010, w},
            {8'h00, fifo_mode, watermark_level});
    for (int n = 1; n <= 33; n++) begin
      pulse(1'b1, 1'b0);
      chk(fsto_pkg::ADDR_FIFO_STATUS, st(n > 32 ? 32 : n, w, n > 32));
    end
    fsto_host_model_inst.wr(fsto_pkg::ADDR_FIFO_STATUS, 8'h00);
    chk(fsto_pkg::ADDR_FIFO_STATUS, st(32, w, 1'b1));
    cmp_val("level_port", 16'h001f, {11'h000, fill_level});
    cmp_val("flag_ports", 16'h0006, {13'h0000, watermark_reached_flag,
            overwrite_flag, fifo_empty});
    for (int n = 31; n >= -1; n--) begin
      pulse(1'b0, 1'b1);
      chk(fsto_pkg::ADDR_FIFO_STATUS, st(n < 0 ? 0 : n, w, 1'b0));
    end
    cmp_val("drain_flags", {13'h0000, w == 5'h00, 2'b01},
            {13'h0000, watermark_reached_flag, overwrite_flag,
             fifo_empty});
    $display("test fifo done");
    repeat (4) @(negedge sys_clk);
    end_sim();
  end
endmodule
